/* File: core/fsps_defs.svh */
// constants of the flash self-programming sequencer
// assumes a 50 MHz system clock and an 8-bit register port
`ifndef FSPS_DEFS_SVH
`define FSPS_DEFS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define FSPS_CTRL_OFS 8'h00
`define FSPS_STAT_OFS 8'h01
`define FSPS_CTRL_RST 8'h00
// ----------------------------------------
// control field positions
// ----------------------------------------
`define FSPS_B_EN 0
`define FSPS_B_ERASE 1
`define FSPS_B_WRITE 2
`define FSPS_B_FUSE 3
`define FSPS_B_CLR 4
`define FSPS_B_RWW 6
`define FSPS_B_IRQEN 7
// ----------------------------------------
// armed commands {fuse, write, erase, enable}
// ----------------------------------------
`define FSPS_CMD_LOAD 4'h1
`define FSPS_CMD_ERASE 4'h3
`define FSPS_CMD_WRITE 4'h5
`define FSPS_CMD_FUSE 4'h9
// ----------------------------------------
// fuse and lock pointers
// ----------------------------------------
`define FSPS_PTR_FLOW 16'h0000
`define FSPS_PTR_LOCK 16'h0001
`define FSPS_PTR_FEXT 16'h0002
`define FSPS_PTR_FHIGH 16'h0003
`define FSPS_BUF_ERASED 16'hFFFF
// ----------------------------------------
// timing
// ----------------------------------------
`define FSPS_STORE_WIN 3'h4
`define FSPS_LOAD_WIN 3'h3
`define FSPS_CLK_NS 20
`define FSPS_PROG_MIN_NS 3200000
`define FSPS_PROG_MAX_NS 3400000
`define FSPS_PAGE_WORDS 32
`endif

/* File: core/fsps_pkg.sv */
// types of the flash self-programming sequencer
// assumes nothing beyond the compile order
package fsps_pkg;
  typedef enum logic [2:0] {
    FSPS_IDLE = 3'b001,
    FSPS_ARMED = 3'b010,
    FSPS_BUSY = 3'b100
  } fsps_state_t;
endpackage

/* File: core/fsps_sequencer.sv */
// flash self-programming sequencer: control register, page buffer, timed commands
// assumes core strobes and eeprom flag come from logic on sys_clk
// ----------------------------------------
// Overview of operation
// R1: store instruction accepted from any flash address
// R2: software erases a page before writing it
// R3: software saves unchanged words before erasing
// R4: buffer words load in any order
// R5: software uses same page for erase, write
// R6: erase command 0x03 plus store within four
// R7: core halted for whole erase
// R8: software disables interrupts around the sequence
// R9: load command writes data word at Z5:Z1
// R10: buffer cleared on write, clear bit, reset
// R11: one load per buffer word between clears
// R12: eeprom write during loading discards the buffer
// R13: write command 0x05 plus store within four
// R14: core halted for whole page write
// R15: program load selects byte with Z0
// R16: eeprom write blocks all commands and reads; flash program loads are not blocked
// R17: software checks eeprom flag before arming
// R18: lock byte read at pointer 0x0001
// R19: fuse bytes read at pointers 0, 2, 3
// R20: fuse read bits clear on use or timeout
// R21: programmed fuse bits read as zero
// R22: erase and write last 3.2 to 3.4 ms
// R23: ready interrupt while idle and enabled
// R24: read-while-write busy bit reads zero
// R25: late or unarmed store is ignored
// R26: enable bit clears when operation completes
// ----------------------------------------
`timescale 1ns/1ps
`include "fsps_defs.svh"

module fsps_sequencer #(
  parameter int PROG_CYCLES = (`FSPS_PROG_MIN_NS + `FSPS_CLK_NS - 1) / `FSPS_CLK_NS
) (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // register write data
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire logic store_req, // program-store instruction
  input wire logic load_req, // program-load instruction
  input wire logic [15:0] ptr_z, // pointer register
  input wire logic [15:0] word_data, // word_data_regs pair
  output logic [7:0] load_data, // program-load result
  output logic load_valid, // result strobe
  output logic core_halt, // stalls the core
  output logic ready_irq, // ready interrupt level
  input wire logic eeprom_write_active, // eeprom write in progress
  input wire logic [7:0] fuse_low_pgm, // fuse_low_byte, 1 = programmed
  input wire logic [7:0] fuse_high_pgm, // fuse_high_byte, 1 = programmed
  input wire logic [7:0] fuse_ext_pgm, // fuse_extended_byte, 1 = programmed
  input wire logic [7:0] lock_pgm, // lock_byte, 1 = programmed
  output logic [14:0] flash_rd_addr, // flash word read address
  input wire logic [15:0] flash_rd_word, // flash word read data
  output logic flash_erase, // page erase start pulse
  output logic [6:0] flash_page, // page_index_field
  output logic flash_wr_en, // page word program strobe
  output logic [4:0] flash_wr_idx, // word_index_field
  output logic [15:0] flash_wr_data // page word data
);

  localparam logic [17:0] LAST_CNT = 18'(PROG_CYCLES - 1);

  fsps_pkg::fsps_state_t state;
  logic irq_en;
  logic [3:0] cmd;
  logic [2:0] win;
  logic [17:0] cnt;
  logic is_write;
  logic [15:0] buf_mem [`FSPS_PAGE_WORDS];
  logic [`FSPS_PAGE_WORDS-1:0] written;
  logic ctrl_wr;
  logic arm_ok;
  logic store_ok;
  logic take_op;
  logic buf_ld;
  logic fuse_take;
  logic op_done;
  logic buf_clear;
  logic ld_pend;
  logic ld_fuse;
  logic ld_byte;
  logic [7:0] fuse_val;
  logic [7:0] next_fuse_val;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  assign ctrl_wr = reg_wr && reg_addr == `FSPS_CTRL_OFS;
  // arming is refused outright while eeprom writes, so nothing can start late
  assign arm_ok = ctrl_wr && reg_wdata[`FSPS_B_EN] && !eeprom_write_active && state != fsps_pkg::FSPS_BUSY; // R16
  // store counts only inside the window; no address range is excluded
  assign store_ok = store_req && win != 3'h0 && !eeprom_write_active && !ctrl_wr; // R1 R25
  assign take_op = store_ok && (cmd == `FSPS_CMD_ERASE || cmd == `FSPS_CMD_WRITE); // R6 R13
  assign buf_ld = store_ok && cmd == `FSPS_CMD_LOAD; // R9
  assign fuse_take = load_req && cmd == `FSPS_CMD_FUSE && !eeprom_write_active
    && win > (`FSPS_STORE_WIN - `FSPS_LOAD_WIN); // R18 R20
  assign op_done = state == fsps_pkg::FSPS_BUSY && cnt == LAST_CNT; // R22
  // a word loaded and then an eeprom write loses the whole buffer
  assign buf_clear = (ctrl_wr && reg_wdata[`FSPS_B_CLR]) || (op_done && is_write)
    || (eeprom_write_active && |written); // R10 R12

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en <= 1'b0;
      cmd <= 4'h0;
    end else begin
      if (ctrl_wr) begin
        irq_en <= reg_wdata[`FSPS_B_IRQEN];
      end
      if (arm_ok) begin
        cmd <= {reg_wdata[`FSPS_B_FUSE], reg_wdata[`FSPS_B_WRITE], reg_wdata[`FSPS_B_ERASE], 1'b1};
      end else if (op_done) begin
        cmd <= 4'h0; // R26
      end else if (buf_ld || fuse_take) begin
        cmd <= 4'h0; // R20
      end else if (win == 3'h1 && !take_op) begin
        cmd <= 4'h0; // R25 R20
      end
    end
  end

  // ----------------------------------------
  // timed window and sequencer state
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      win <= 3'h0;
    end else if (arm_ok) begin
      win <= `FSPS_STORE_WIN; // R6 R9 R13
    end else if (take_op || buf_ld || fuse_take) begin
      win <= 3'h0;
    end else if (win != 3'h0) begin
      win <= win - 3'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= fsps_pkg::FSPS_IDLE;
      cnt <= 18'h00000;
      is_write <= 1'b0;
    end else begin
      unique case (state)
        fsps_pkg::FSPS_IDLE: begin
          if (arm_ok) begin
            state <= fsps_pkg::FSPS_ARMED;
          end
        end
        fsps_pkg::FSPS_ARMED: begin
          if (take_op) begin
            state <= fsps_pkg::FSPS_BUSY; // R7 R14
            cnt <= 18'h00000;
            is_write <= cmd == `FSPS_CMD_WRITE;
          end else if (arm_ok) begin
            state <= fsps_pkg::FSPS_ARMED;
          end else if (win <= 3'h1 || buf_ld || fuse_take) begin
            state <= fsps_pkg::FSPS_IDLE;
          end
        end
        fsps_pkg::FSPS_BUSY: begin
          // time is counted on sys_clk, standing in for the calibrated oscillator
          if (op_done) begin
            state <= fsps_pkg::FSPS_IDLE; // R22
          end else begin
            cnt <= cnt + 18'h00001;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // temporary page buffer, one word per entry
  // ----------------------------------------
  for (genvar i = 0; i < `FSPS_PAGE_WORDS; i++) begin : g_buf
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        buf_mem[i] <= `FSPS_BUF_ERASED; // R10
        written[i] <= 1'b0;
      end else if (buf_clear) begin
        buf_mem[i] <= `FSPS_BUF_ERASED; // R10
        written[i] <= 1'b0;
      end else if (buf_ld && ptr_z[5:1] == 5'(i) && !written[i]) begin
        buf_mem[i] <= word_data; // R4 R9 R11
        written[i] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // flash array side
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_erase <= 1'b0;
      flash_page <= 7'h00;
      flash_wr_en <= 1'b0;
      flash_wr_idx <= 5'h00;
      flash_wr_data <= 16'h0000;
      core_halt <= 1'b0;
    end else begin
      flash_erase <= take_op && cmd == `FSPS_CMD_ERASE; // R6
      if (take_op) begin
        flash_page <= ptr_z[12:6]; // R6 R13
      end
      // the page streams out at the start of the write, before the buffer clears
      flash_wr_en <= state == fsps_pkg::FSPS_BUSY && is_write && cnt < 18'(`FSPS_PAGE_WORDS);
      flash_wr_idx <= cnt[4:0];
      flash_wr_data <= buf_mem[cnt[4:0]];
      core_halt <= take_op || (state == fsps_pkg::FSPS_BUSY && !op_done); // R7 R14
    end
  end

  // ----------------------------------------
  // program-load path, two cycles for flash and fuse alike
  // ----------------------------------------
  always_comb begin
    unique case (ptr_z)
      `FSPS_PTR_FLOW: next_fuse_val = ~fuse_low_pgm; // R19 R21
      `FSPS_PTR_LOCK: next_fuse_val = ~lock_pgm; // R18 R21
      `FSPS_PTR_FEXT: next_fuse_val = ~fuse_ext_pgm; // R19 R21
      `FSPS_PTR_FHIGH: next_fuse_val = ~fuse_high_pgm; // R19 R21
      default: next_fuse_val = 8'hFF;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ld_pend <= 1'b0;
      ld_fuse <= 1'b0;
      ld_byte <= 1'b0;
      fuse_val <= 8'h00;
      flash_rd_addr <= 15'h0000;
    end else begin
      ld_pend <= load_req;
      ld_fuse <= fuse_take;
      ld_byte <= ptr_z[0]; // R15
      fuse_val <= next_fuse_val;
      if (load_req) begin
        flash_rd_addr <= ptr_z[15:1]; // R15
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_data <= 8'h00;
      load_valid <= 1'b0;
    end else begin
      load_valid <= ld_pend;
      if (ld_fuse) begin
        load_data <= fuse_val;
      end else if (ld_pend) begin
        load_data <= ld_byte ? flash_rd_word[15:8] : flash_rd_word[7:0]; // R15
      end
    end
  end

  // ----------------------------------------
  // register read port and ready interrupt
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `FSPS_CTRL_RST;
    end else if (reg_rd && reg_addr == `FSPS_CTRL_OFS) begin
      // read-while-write busy never sets on this part
      reg_rdata <= {irq_en, 1'b0, 2'b00, cmd}; // R24
    end else if (reg_rd && reg_addr == `FSPS_STAT_OFS) begin
      reg_rdata <= {3'b000, state, eeprom_write_active, |written};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_irq <= 1'b0;
    end else begin
      ready_irq <= irq_en && !cmd[`FSPS_B_EN] && !eeprom_write_active && state != fsps_pkg::FSPS_BUSY
        && !take_op; // R23
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_erase_taken;
    take_op && cmd == `FSPS_CMD_ERASE;
  endsequence

  sequence s_held;
    core_halt [*8];
  endsequence

  AST_ERASE_HALT: assert property (s_erase_taken |=> (flash_erase and s_held)) // R7
    else $error("erase did not pulse and halt the core");
  AST_WRITE_HALT: assert property (take_op && cmd == `FSPS_CMD_WRITE |=> s_held) // R14
    else $error("page write did not halt the core");
  AST_OP_LENGTH: assert property ($fell(core_halt) |-> $past(cnt) == LAST_CNT) // R22
    else $error("operation ended before its programmed time");
  AST_LOAD_ONCE: assert property (buf_ld && written[ptr_z[5:1]] && !buf_clear
    |=> buf_mem[$past(ptr_z[5:1])] == $past(buf_mem[ptr_z[5:1]])) // R11
    else $error("second load overwrote a buffer word");
  AST_WRITE_CLEARS: assert property (op_done && is_write |=> written == '0) // R10
    else $error("buffer not cleared after page write");
  AST_EEPROM_BLOCK: assert property (ctrl_wr && eeprom_write_active |=> win == 3'h0) // R16
    else $error("command armed during eeprom write");
  AST_WINDOW_EXPIRES: assert property (arm_ok ##1 (!store_req && !load_req && !arm_ok) [*4]
    |=> cmd == 4'h0) // R25 R20
    else $error("armed command survived its window");
  AST_FUSE_LOW: assert property (fuse_take && ptr_z == `FSPS_PTR_FLOW
    |-> ##2 load_valid && load_data == ~$past(fuse_low_pgm, 2)) // R19 R21
    else $error("fuse low byte returned wrongly");
  AST_ENABLE_CLEARS: assert property (op_done |=> !cmd[`FSPS_B_EN] && !core_halt) // R26
    else $error("enable still set after completion");
  AST_RWW_ZERO: assert property (reg_rd && reg_addr == `FSPS_CTRL_OFS |=> !reg_rdata[`FSPS_B_RWW]) // R24
    else $error("rww busy bit read as one");
  AST_IRQ_QUIET: assert property (ready_irq |-> !core_halt && !$past(eeprom_write_active)) // R23
    else $error("ready interrupt during busy or eeprom write");

endmodule

/* File: dv/fsps_flash_model.sv */
// flash array model: answers word reads, takes page erase and word programming
// assumes a 12-bit word space {page, word} and registered strobes on sys_clk
`timescale 1ns/1ps
module fsps_flash_model (
  input wire logic sys_clk, // system clock
  input wire logic [14:0] flash_rd_addr, // word read address
  output logic [15:0] flash_rd_word, // word read data
  input wire logic flash_erase, // page erase pulse
  input wire logic [6:0] flash_page, // page index
  input wire logic flash_wr_en, // word program strobe
  input wire logic [4:0] flash_wr_idx, // word index
  input wire logic [15:0] flash_wr_data // word data
);
  logic [15:0] mem [0:4095];
  assign flash_rd_word = mem[flash_rd_addr[11:0]];
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 16'hFFFF;
    end
  end
  // programming only clears bits, so a write to an unerased page shows up
  // updates are non-blocking so a read in the same edge sees the old word
  always @(posedge sys_clk) begin
    if (flash_erase) begin
      for (int i = 0; i < 32; i++) begin
        mem[{flash_page, i[4:0]}] <= 16'hFFFF;
      end
    end
    if (flash_wr_en) begin
      mem[{flash_page, flash_wr_idx}] <= mem[{flash_page, flash_wr_idx}] & flash_wr_data;
    end
  end
endmodule

/* File: dv/testbench.sv */
// self-checking bench of the flash self-programming sequencer
// assumes the flash model answers reads in the same cycle
`timescale 1ns/1ps
`include "fsps_defs.svh"
module testbench;
  localparam int PC = 40;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, load_data, v;
  logic reg_wr = 1'b0, reg_rd = 1'b0, store_req = 1'b0, load_req = 1'b0;
  logic eeprom_write_active = 1'b0, load_valid, core_halt, ready_irq, flash_erase, flash_wr_en;
  logic [15:0] ptr_z = 16'h0000, word_data = 16'h0000, flash_rd_word, flash_wr_data;
  logic [7:0] fuse_low_pgm = 8'h62, fuse_high_pgm = 8'hD9, fuse_ext_pgm = 8'hFC, lock_pgm = 8'h3C;
  logic [14:0] flash_rd_addr;
  logic [6:0] flash_page;
  logic [4:0] flash_wr_idx;
  int error_cnt = 0, total_checks = 0;
  always #10 sys_clk = ~sys_clk;
  fsps_sequencer #(.PROG_CYCLES(PC)) u_fsps_sequencer (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .store_req, .load_req, .ptr_z, .word_data, .load_data, .load_valid, .core_halt,
    .ready_irq, .eeprom_write_active, .fuse_low_pgm, .fuse_high_pgm, .fuse_ext_pgm, .lock_pgm,
    .flash_rd_addr, .flash_rd_word, .flash_erase, .flash_page, .flash_wr_en, .flash_wr_idx, .flash_wr_data);
  fsps_flash_model u_fsps_flash_model (.sys_clk, .flash_rd_addr, .flash_rd_word, .flash_erase,
    .flash_page, .flash_wr_en, .flash_wr_idx, .flash_wr_data);
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function automatic logic [15:0] zp(input int p, input int w);
    return 16'((p << 6) | (w << 1));
  endfunction
  task automatic arm(input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= `FSPS_CTRL_OFS;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // late counts extra cycles between the control write and the store
  task automatic spm(input logic [7:0] d, input logic [15:0] z, input logic [15:0] w, input int late);
    arm(d);
    repeat (late) @(posedge sys_clk);
    store_req <= 1'b1;
    ptr_z <= z;
    word_data <= w;
    @(posedge sys_clk);
    store_req <= 1'b0;
  endtask
  task automatic ld(input logic [15:0] z);
    int n;
    load_req <= 1'b1;
    ptr_z <= z;
    @(posedge sys_clk);
    load_req <= 1'b0;
    #1;
    for (n = 0; n < 5 && load_valid !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    if (load_valid !== 1'b1) begin
      chk("load_valid", 16'h0000, 16'h0001);
      conclude();
    end
    v = load_data;
  endtask
  task automatic rdb(input logic [15:0] z, input logic [7:0] exp);
    @(posedge sys_clk);
    ld(z);
    chk("flash byte", 16'(v), 16'(exp));
  endtask
  // entered at the edge that takes the store
  task automatic halt_len(input logic e, input logic [6:0] p);
    int n;
    n = 0;
    #1;
    chk("erase pulse", 16'(flash_erase), 16'(e));
    chk("flash page", 16'(flash_page), 16'(p));
    for (int i = 0; i < 3 * PC && core_halt === 1'b1; i++) begin
      n++;
      @(posedge sys_clk);
      #1;
    end
    chk("halt cycles", 16'(n), 16'(PC));
    rd(`FSPS_CTRL_OFS);
    chk("ctrl after op", 16'(v), 16'h0000);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd(`FSPS_CTRL_OFS);
    chk("ctrl reset", 16'(v), 16'h0000);
    rd(`FSPS_STAT_OFS);
    chk("status reset", 16'(v), 16'h0004);
    rd(8'h7F);
    chk("unmapped", 16'(v), 16'h0000);
    arm(8'h80);
    repeat (2) @(posedge sys_clk);
    #1 chk("irq on", 16'(ready_irq), 16'h0001);
    eeprom_write_active <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk("irq eeprom", 16'(ready_irq), 16'h0000);
    eeprom_write_active <= 1'b0;
    rd(`FSPS_CTRL_OFS);
    chk("ctrl irq en", 16'(v), 16'h0080);
    arm(8'h00);
    repeat (2) @(posedge sys_clk);
    #1 chk("irq off", 16'(ready_irq), 16'h0000);
  endtask
  task automatic t_page3();
    spm(8'h01, zp(3, 5), 16'h5555, 0);
    arm(8'h10);
    spm(8'h01, zp(3, 5), 16'h1234, 0);
    spm(8'h01, zp(3, 2), 16'hABCD, 2);
    spm(8'h01, zp(3, 5), 16'h0000, 0);
    spm(8'h03, zp(3, 0) | 16'h003F, 16'h0000, 0);
    halt_len(1'b1, 7'h03);
    spm(8'h05, zp(3, 0), 16'h0000, 3);
    halt_len(1'b0, 7'h03);
    rdb(zp(3, 5), 8'h34);
    rdb(zp(3, 5) | 16'h0001, 8'h12);
    rdb(zp(3, 2) | 16'h0001, 8'hAB);
    rdb(zp(3, 0), 8'hFF);
  endtask
  task automatic t_page4();
    spm(8'h01, zp(4, 1), 16'h6666, 0);
    @(posedge sys_clk);
    eeprom_write_active <= 1'b1;
    arm(8'h01);
    rd(`FSPS_CTRL_OFS);
    chk("arm refused", 16'(v), 16'h0000);
    eeprom_write_active <= 1'b0;
    spm(8'h01, zp(4, 1), 16'h8888, 4);
    spm(8'h01, zp(4, 1), 16'h7777, 0);
    spm(8'h03, zp(4, 0), 16'h0000, 0);
    halt_len(1'b1, 7'h04);
    spm(8'h05, zp(4, 0), 16'h0000, 0);
    halt_len(1'b0, 7'h04);
    rdb(zp(4, 1), 8'h77);
    rdb(zp(4, 5), 8'hFF);
  endtask
  task automatic t_fuse();
    logic [7:0] e;
    for (int z = 0; z < 4; z++) begin
      case (z)
        0: e = ~fuse_low_pgm;
        1: e = ~lock_pgm;
        2: e = ~fuse_ext_pgm;
        default: e = ~fuse_high_pgm;
      endcase
      arm(8'h09);
      ld(16'(z));
      chk("fuse byte", 16'(v), 16'(e));
      rd(`FSPS_CTRL_OFS);
      chk("fuse bits clear", 16'(v), 16'h0000);
    end
    arm(8'h09);
    repeat (6) @(posedge sys_clk);
    rd(`FSPS_CTRL_OFS);
    chk("fuse expiry", 16'(v), 16'h0000);
    arm(8'h09);
    repeat (3) @(posedge sys_clk);
    ld(zp(3, 5));
    chk("late load", 16'(v), 16'h0034);
    rdb(zp(3, 5), 8'h34);
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_page3();
    t_page4();
    t_fuse();
    conclude();
  end
endmodule
